// File: embi_pkg.sv
// Package for the external memory and boot interface.
// Assumes one 200 MHz clock, synchronous active-low reset.
package embi_pkg;
  localparam logic [13:0] EXT_CODE_BASE_LO = 14'h0800;
  localparam logic [13:0] INT_CODE_BASE_HI = 14'h3800;
  localparam logic [13:0] INT_CODE_END_HI  = 14'h39ff;
  localparam logic [13:0] INT_CODE_END_LO  = 14'h01ff;
  localparam logic [13:0] INT_DATA_BASE    = 14'h3800;
  localparam logic [13:0] INT_DATA_END     = 14'h38ff;
  localparam logic [13:0] RSVD_DATA_BASE   = 14'h3900;
  localparam logic [2:0]  CODE_WAIT_RST    = 3'h7;
  localparam logic [2:0]  DATA_WAIT_RST    = 3'h7;
  localparam logic [2:0]  BOOT_WAIT_RST    = 3'h3;
  localparam int          NUM_ZONES        = 5;
  localparam logic [9:0]  BOOT_WORDS       = 10'h200;
  // Wishbone register offsets
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_WAIT         = 8'h04;
  localparam logic [7:0]  REG_LOWBYTE      = 8'h08;
  localparam logic [7:0]  REG_STATUS       = 8'h0c;
  // Control field positions
  localparam int          CTRL_PAGE_LSB    = 0;
  localparam int          CTRL_FORCE_BIT   = 3;
  localparam int          CTRL_GO_BIT      = 4;

  typedef enum logic [1:0] {
    EMBI_SP_CODE,
    EMBI_SP_DATA
  } embi_space_t;

  typedef struct packed {
    logic        valid;
    embi_space_t space;
    logic        write;
    logic        wide16;
    logic [13:0] addr;
    logic [23:0] wdata;
  } embi_req_t;

  typedef struct packed {
    logic        done;
    logic        internal;
    logic [23:0] rdata;
  } embi_rsp_t;
endpackage

// File: embi_top.sv
// External memory mux, boot loader and bus arbitration.
// Assumes the core holds a request until done; internal RAM lies outside.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module embi_top
  import embi_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Strap and arbitration
  input  wire logic        memory_layout_select,
  input  wire logic        bus_request_n,
  output logic             bus_grant_n,
  output logic             core_halt,
  // Core request
  input  wire embi_req_t   core_req,
  output embi_rsp_t        core_rsp,
  // Internal code RAM write port for boot
  output logic             boot_we,
  output logic [8:0]       boot_waddr,
  output logic [23:0]      boot_wdata,
  output logic             boot_busy,
  // External pins
  output logic [13:0]      ext_addr,
  output logic             ext_addr_oe,
  input  wire logic [23:0] ext_data_i,
  output logic [23:0]      ext_data_o,
  output logic             ext_data_oe,
  output logic             code_space_select_n,
  output logic             data_space_select_n,
  output logic             boot_space_select_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             ctl_oe,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACC,
    ST_BOOT,
    ST_DONE
  } embi_st_t;

  embi_st_t    st_q;
  logic [2:0]  code_wait_q;
  logic [2:0]  boot_wait_q;
  logic [2:0]  zone_wait_q [NUM_ZONES];
  logic [2:0]  boot_page_q;
  logic        force_q;
  logic        go_q;
  logic [7:0]  low_byte_q;
  logic [2:0]  wcnt_q;
  logic [1:0]  byte_q;
  logic [9:0]  word_q;
  logic [10:0] baddr_q;
  logic [23:0] pack_q;
  logic        granted_q;
  logic        boot_pend_q;
  logic        rst_seen_q;
  embi_req_t   cur_q;

  // Internal or external decode per layout
  function automatic logic is_internal(input embi_req_t r, input logic lay);
    if (r.space == EMBI_SP_DATA) begin
      is_internal = (r.addr >= INT_DATA_BASE);
    end else if (lay) begin
      is_internal = (r.addr >= INT_CODE_BASE_HI) && (r.addr <= INT_CODE_END_HI);
    end else begin
      is_internal = (r.addr < EXT_CODE_BASE_LO);
    end
  endfunction

  // Zone of an external data address
  function automatic logic [2:0] zone_of(input logic [13:0] a);
    if (a < 14'h0800) begin
      zone_of = 3'h0;
    end else if (a < 14'h1000) begin
      zone_of = 3'h1;
    end else if (a < 14'h2000) begin
      zone_of = 3'h2;
    end else if (a < 14'h3000) begin
      zone_of = 3'h3;
    end else begin
      zone_of = 3'h4;
    end
  endfunction

  logic req_n;
  logic ext_req;
  logic [2:0] acc_wait;
  assign req_n   = ~bus_request_n;
  assign ext_req = core_req.valid && !is_internal(core_req, memory_layout_select);
  assign acc_wait = (core_req.space == EMBI_SP_CODE) ? code_wait_q
                  : zone_wait_q[zone_of(core_req.addr)];

  // Register file and Wishbone slave
  always_ff @(posedge clk) begin
    if (!resetn) begin
      code_wait_q <= CODE_WAIT_RST;
      boot_wait_q <= BOOT_WAIT_RST;
      for (int i = 0; i < NUM_ZONES; i++) begin
        zone_wait_q[i] <= DATA_WAIT_RST;
      end
      boot_page_q <= 3'h0;
      force_q     <= 1'b0;
      go_q        <= 1'b0;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (st_q == ST_BOOT) begin
        force_q <= 1'b0;
      end
      // Writes land on the edge where the master sees ack
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
        if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
          boot_page_q <= wb_dat_i[CTRL_PAGE_LSB +: 3];
          force_q     <= wb_dat_i[CTRL_FORCE_BIT];
          go_q        <= wb_dat_i[CTRL_GO_BIT];
        end else if (wb_adr_i == REG_WAIT) begin
          code_wait_q <= wb_dat_i[2:0];
          boot_wait_q <= wb_dat_i[6:4];
          for (int i = 0; i < NUM_ZONES; i++) begin
            zone_wait_q[i] <= wb_dat_i[8 + 4 * i +: 3];
          end
        end
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= 32'h0;
        if (wb_adr_i == REG_CTRL) begin
          wb_dat_o <= {27'h0, go_q, force_q, boot_page_q};
        end else if (wb_adr_i == REG_WAIT) begin
          wb_dat_o <= {5'h0, zone_wait_q[4], 1'b0, zone_wait_q[3], 1'b0, zone_wait_q[2],
                       1'b0, zone_wait_q[1], 1'b0, zone_wait_q[0], 1'b0, boot_wait_q,
                       1'b0, code_wait_q};
        end else if (wb_adr_i == REG_LOWBYTE) begin
          wb_dat_o <= {24'h0, low_byte_q};
        end else if (wb_adr_i == REG_STATUS) begin
          wb_dat_o <= {29'h0, boot_busy, ~bus_grant_n, memory_layout_select};
        end
      end
    end
  end

  // Main sequencer: accesses, boot, grant
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q        <= ST_IDLE;
      wcnt_q      <= 3'h0;
      byte_q      <= 2'h0;
      word_q      <= 10'h0;
      baddr_q     <= 11'h0;
      pack_q      <= 24'h0;
      boot_pend_q <= 1'b0;
      rst_seen_q  <= 1'b0;
      cur_q       <= '0;
      low_byte_q  <= 8'h0;
    end else if (ce) begin
      rst_seen_q <= 1'b1;
      if (!rst_seen_q && !memory_layout_select && !req_n) begin
        boot_pend_q <= 1'b1;
      end
      if (force_q) begin
        boot_pend_q <= 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          if (granted_q || req_n) begin
            st_q <= ST_IDLE;
          end else if (boot_pend_q) begin
            st_q    <= ST_BOOT;
            byte_q  <= 2'h0;
            word_q  <= 10'h0;
            baddr_q <= 11'h0;
            wcnt_q  <= boot_wait_q;
          // Done still shows: the held request is the one just finished
          end else if (ext_req && !core_rsp.done) begin
            st_q   <= ST_ACC;
            cur_q  <= core_req;
            wcnt_q <= acc_wait;
          end
        end
        ST_ACC: begin
          if (wcnt_q != 3'h0) begin
            wcnt_q <= wcnt_q - 3'h1;
          end else begin
            st_q <= ST_DONE;
          end
        end
        // Strobes still stand here, so zero wait states read settled data
        ST_DONE: begin
          st_q <= ST_IDLE;
          if (cur_q.space == EMBI_SP_CODE && cur_q.wide16 && !cur_q.write) begin
            low_byte_q <= ext_data_i[7:0];
          end
        end
        ST_BOOT: begin
          if (wcnt_q != 3'h0) begin
            wcnt_q <= wcnt_q - 3'h1;
          end else begin
            pack_q  <= {pack_q[15:0], ext_data_i[15:8]};
            baddr_q <= baddr_q + 11'h1;
            wcnt_q  <= boot_wait_q;
            if (byte_q == 2'h2) begin
              byte_q <= 2'h0;
              word_q <= word_q + 10'h1;
              if (word_q == BOOT_WORDS - 10'h1) begin
                boot_pend_q <= 1'b0;
                st_q        <= ST_IDLE;
              end
            end else begin
              byte_q <= byte_q + 2'h1;
            end
            if (req_n) begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Grant: only between accesses, works during reset too
  always_ff @(posedge clk) begin
    if (!resetn) begin
      granted_q   <= req_n;
      bus_grant_n <= !granted_q;
    end else if (ce) begin
      if (!req_n) begin
        granted_q <= 1'b0;
      end else if (st_q == ST_IDLE || st_q == ST_DONE) begin
        granted_q <= 1'b1;
      end
      bus_grant_n <= !granted_q;
    end
  end

  // Pin and core outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_addr            <= 14'h0;
      ext_addr_oe         <= 1'b0;
      ext_data_o          <= 24'h0;
      ext_data_oe         <= 1'b0;
      code_space_select_n <= 1'b1;
      data_space_select_n <= 1'b1;
      boot_space_select_n <= 1'b1;
      rd_n                <= 1'b1;
      wr_n                <= 1'b1;
      ctl_oe              <= 1'b0;
      core_rsp            <= '0;
      core_halt           <= 1'b1;
      boot_we             <= 1'b0;
      boot_waddr          <= 9'h0;
      boot_wdata          <= 24'h0;
      boot_busy           <= 1'b0;
    end else if (ce) begin
      ctl_oe      <= !granted_q;
      ext_addr_oe <= !granted_q;
      code_space_select_n <= !(st_q == ST_ACC && cur_q.space == EMBI_SP_CODE);
      data_space_select_n <= !(st_q == ST_ACC && cur_q.space == EMBI_SP_DATA);
      boot_space_select_n <= !(st_q == ST_BOOT);
      rd_n <= !((st_q == ST_ACC && !cur_q.write) || st_q == ST_BOOT);
      wr_n <= !(st_q == ST_ACC && cur_q.write);
      ext_data_oe <= !granted_q && st_q == ST_ACC && cur_q.write;
      if (st_q == ST_BOOT) begin
        ext_addr   <= {boot_page_q[0], 2'h0, baddr_q};
        ext_data_o <= {boot_page_q[2:1], 22'h0};
        ext_data_oe <= 1'b1;
      end else begin
        ext_addr <= cur_q.addr;
        if (cur_q.space == EMBI_SP_DATA) begin
          ext_data_o <= {cur_q.wdata[15:0], 8'h0};
        end else if (cur_q.wide16) begin
          ext_data_o <= {cur_q.wdata[15:0], low_byte_q};
        end else begin
          ext_data_o <= cur_q.wdata;
        end
      end
      core_rsp.done     <= (st_q == ST_DONE) ||
                           (core_req.valid && !ext_req && !core_rsp.done);
      core_rsp.internal <= core_req.valid && !ext_req;
      if (st_q == ST_DONE) begin
        if (cur_q.space == EMBI_SP_DATA || cur_q.wide16) begin
          core_rsp.rdata <= {8'h0, ext_data_i[23:8]};
        end else begin
          core_rsp.rdata <= ext_data_i;
        end
      end
      // Halt on grant unless keep-running mode and no external need
      core_halt <= (granted_q && (!go_q || ext_req)) || boot_pend_q;
      boot_we    <= st_q == ST_BOOT && wcnt_q == 3'h0 && byte_q == 2'h2;
      boot_waddr <= word_q[8:0];
      boot_wdata <= {pack_q[15:0], ext_data_i[15:8]};
      boot_busy  <= boot_pend_q;
    end
  end

  // Assertions
  AST_GRANT_FLOATS: assert property (@(posedge clk) disable iff (!resetn)
    ce && granted_q ##1 ce |-> !ctl_oe && !ext_data_oe)
    else $error("Bus not floated while granted");
  AST_NO_GRANT_MID_ACC: assert property (@(posedge clk) disable iff (!resetn)
    st_q == ST_ACC && wcnt_q != 3'h0 && !granted_q |=> !granted_q)
    else $error("Grant given during an access");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
    ce && !req_n |=> !granted_q)
    else $error("Grant held after request removed");
  AST_CODE_WAIT_RST: assert property (@(posedge clk)
    !resetn |=> code_wait_q == CODE_WAIT_RST)
    else $error("Code wait reset wrong");
  AST_BOOT_WAIT_RST: assert property (@(posedge clk)
    !resetn |=> boot_wait_q == BOOT_WAIT_RST)
    else $error("Boot wait reset wrong");
  AST_ZONE_WAIT_RST: assert property (@(posedge clk)
    !resetn |=> zone_wait_q[4] == DATA_WAIT_RST && zone_wait_q[0] == DATA_WAIT_RST)
    else $error("Zone wait reset wrong");
  AST_BOOT_SELECT: assert property (@(posedge clk) disable iff (!resetn)
    ce && st_q == ST_BOOT |=> !boot_space_select_n && !rd_n)
    else $error("Boot select missing");
  AST_NO_BOOT_HI: assert property (@(posedge clk) disable iff (!resetn)
    memory_layout_select && !force_q && !boot_pend_q |=> !boot_pend_q)
    else $error("Boot started with layout high");
endmodule

// File: embi_ext_model.sv
// External code, data and boot memories on the shared pins.
// Assumes active-low selects and strobes; the data array is word wide.
`timescale 1ns/1ps
module embi_ext_model
  import embi_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Pins
  input  wire logic [13:0] ext_addr,
  input  wire logic [23:0] ext_data_o,
  input  wire logic        code_space_select_n,
  input  wire logic        data_space_select_n,
  input  wire logic        boot_space_select_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic [23:0]      ext_data_i
);
  logic [23:0] mem [0:16383];
  logic [23:0] last_q = 24'h000000;
  logic        sel;

  assign sel = !(code_space_select_n && data_space_select_n);

  // Store on the write strobe
  always @(posedge clk) begin
    if (!wr_n && sel) mem[ext_addr] <= ext_data_o;
    last_q <= ext_data_i;
  end

  // Boot bytes on the middle lane; a released bus shows the inverse
  always_comb begin
    if (!rd_n && !boot_space_select_n) begin
      ext_data_i = {~last_q[23:16], ext_addr[7:0] ^ 8'h5a, ~last_q[7:0]};
    end else if (!rd_n && sel) begin
      ext_data_i = mem[ext_addr];
    end else begin
      ext_data_i = ~last_q;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the external memory and boot interface.
// Assumes the hand-over timing: one-cycle bus ack, one done pulse per access.
`timescale 1ns/1ps
module tb
  import embi_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        memory_layout_select = 1'b0;
  logic        bus_request_n = 1'b0;
  embi_req_t   core_req = '0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        bus_grant_n, core_halt, boot_we, boot_busy, ext_addr_oe, ext_data_oe;
  logic        code_space_select_n, data_space_select_n, boot_space_select_n;
  logic        rd_n, wr_n, ctl_oe, wb_ack_o;
  embi_rsp_t   core_rsp;
  logic [8:0]  boot_waddr, last_wa;
  logic [13:0] ext_addr;
  logic [23:0] boot_wdata, ext_data_i, ext_data_o, rd, last_wd;
  logic [31:0] wb_dat_o, q;
  logic [2:0]  pg;
  logic        ins;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  int          strb = 0;
  int          viol = 0;

  embi_top embi_top_inst (
    .clk, .resetn, .ce, .memory_layout_select, .bus_request_n, .bus_grant_n, .core_halt,
    .core_req, .core_rsp, .boot_we, .boot_waddr, .boot_wdata, .boot_busy, .ext_addr,
    .ext_addr_oe, .ext_data_i, .ext_data_o, .ext_data_oe, .code_space_select_n,
    .data_space_select_n, .boot_space_select_n, .rd_n, .wr_n, .ctl_oe, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
  );

  embi_ext_model embi_ext_model_inst (
    .clk, .ext_addr, .ext_data_o, .code_space_select_n, .data_space_select_n,
    .boot_space_select_n, .rd_n, .wr_n, .ext_data_i
  );

  always #2.5 clk = ~clk;

  // Strobe length, boot page lines, word writes, drivers on while granted
  always @(negedge clk) begin
    if (!(rd_n && wr_n) && !(code_space_select_n && data_space_select_n)) strb++;
    if (!boot_space_select_n) pg = {ext_data_o[23:22], ext_addr[13]};
    if (boot_we === 1'b1) begin
      last_wa = boot_waddr;
      last_wd = boot_wdata;
    end
    if (!bus_grant_n && (ctl_oe || ext_addr_oe || ext_data_oe)) viol++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
    if (k == 20) chk(0, 1);
  endtask

  task automatic acc(input embi_space_t sp, input logic w, input logic w16,
                     input logic [13:0] a, input logic [23:0] d, output int k);
    k = 0;
    strb = 0;
    core_req <= '{1'b1, sp, w, w16, a, d};
    do begin
      @(posedge clk);
      k++;
    end while (core_rsp.done !== 1'b1 && k < 60);
    rd = core_rsp.rdata;
    ins = core_rsp.internal;
    if (k == 60) chk(0, 1);
    core_req.valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic grant(input logic go, input int lim);
    int k;
    k = 0;
    bus_request_n <= 1'b0;
    do begin
      @(posedge clk);
      k++;
    end while (bus_grant_n !== 1'b0 && k < 20);
    chk(k <= lim, 1);
    chk(core_halt, !go);
    bus_request_n <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (bus_grant_n !== 1'b1 && k < 20);
    chk(k <= 4, 1);
  endtask

  task automatic wait_boot;
    int k;
    k = 0;
    while (boot_busy !== 1'b0 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    chk(k < 9000, 1);
  endtask

  initial begin
    int n;
    int n7;
    repeat (8) @(posedge clk);
    chk(bus_grant_n, 0);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(bus_grant_n, 0);
    chk(boot_busy, 0);
    bus_request_n <= 1'b1;
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (100) @(posedge clk);
    chk(boot_busy, 1);
    grant(0, 8);
    wait_boot();
    chk(last_wa, 9'h1ff);
    chk(last_wd, 24'ha7a4a5);
    chk(pg, 3'h0);
    wb(0, REG_WAIT, 32'h0);
    chk(q, 32'h07777737);
    wb(0, 8'h10, 32'h0);
    chk(q, 32'h0);
    acc(EMBI_SP_CODE, 1, 0, 14'h0900, 24'h123456, n);
    chk(embi_ext_model_inst.mem[14'h0900], 24'h123456);
    chk(strb, 8);
    acc(EMBI_SP_CODE, 0, 1, 14'h0900, 24'h0, n7);
    chk(rd[15:0], 16'h1234);
    wb(0, REG_LOWBYTE, 32'h0);
    chk(q[7:0], 8'h56);
    acc(EMBI_SP_CODE, 1, 1, 14'h0901, 24'h000a0b, n);
    chk(embi_ext_model_inst.mem[14'h0901], 24'h0a0b56);
    acc(EMBI_SP_DATA, 1, 0, 14'h0100, 24'h00beef, n);
    chk(embi_ext_model_inst.mem[14'h0100][23:8], 16'hbeef);
    chk(strb, 8);
    acc(EMBI_SP_DATA, 0, 0, 14'h0100, 24'h0, n);
    chk(rd[15:0], 16'hbeef);
    chk(ins, 0);
    acc(EMBI_SP_DATA, 0, 0, 14'h3800, 24'h0, n);
    chk(ins, 1);
    chk(strb, 0);
    acc(EMBI_SP_CODE, 0, 0, 14'h01ff, 24'h0, n);
    chk(ins, 1);
    wb(1, REG_WAIT, 32'h07777730);
    acc(EMBI_SP_CODE, 0, 1, 14'h0900, 24'h0, n);
    chk(strb, 1);
    chk(n7 - n, 7);
    grant(0, 4);
    wb(1, REG_CTRL, 32'h10);
    grant(1, 4);
    wb(1, REG_CTRL, 32'h0);
    fork
      acc(EMBI_SP_DATA, 0, 0, 14'h0100, 24'h0, n);
      begin
        repeat (3) @(posedge clk);
        bus_request_n <= 1'b0;
      end
    join
    chk(rd[15:0], 16'hbeef);
    repeat (4) @(posedge clk);
    chk(bus_grant_n, 0);
    bus_request_n <= 1'b1;
    repeat (4) @(posedge clk);
    memory_layout_select <= 1'b1;
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (20) @(posedge clk);
    chk(boot_busy, 0);
    acc(EMBI_SP_CODE, 1, 0, 14'h0000, 24'h654321, n);
    chk(embi_ext_model_inst.mem[14'h0000], 24'h654321);
    chk(ins, 0);
    acc(EMBI_SP_CODE, 0, 0, 14'h3900, 24'h0, n);
    chk(ins, 1);
    wb(1, REG_CTRL, 32'h0d);
    repeat (20) @(posedge clk);
    chk(pg, 3'h5);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    n = last_wa;
    repeat (30) @(posedge clk);
    chk(last_wa, n);
    ce <= 1'b1;
    wait_boot();
    chk(viol, 0);
    end_sim();
  end
endmodule
